// *** rtl/iep_pkg.sv ***
/*
 contents: constants, register map and bus carrier types of the interrupt
 enable / pending bit banks.
 assumes: one 100 MHz clock, synchronous active-low reset, AXI4-Lite master.
*/
// Overview of operation
// - write 1 to upper enable-clear bits 17..0 disables interrupts 49..32
// - enable-clear read returns enable state, 1 enabled, 0 disabled
// - lower pending-set bit n is interrupt n; writing 1 makes it pending
// - pending-set 1 ignored when interrupt already pending or disabled
// - writing 0 to enable-clear or pending-set bits changes nothing
// - pending-set read returns pending state, 1 pending, 0 not pending
// - pending-clear 1 clears shared pending bit seen by pending-set view
// - pending-clear 1 has no effect while interrupt is being serviced
package iep_pkg;

   localparam int unsigned NUM_IRQ = 50;
   localparam int unsigned HI_BITS = 18;
   localparam int unsigned AW      = 12;
   localparam int unsigned NUM_EVT = 2;

   // register byte offsets
   localparam logic [AW-1:0] OFS_EN_SET_LO = 12'h000;
   localparam logic [AW-1:0] OFS_EN_SET_HI = 12'h004;
   localparam logic [AW-1:0] OFS_EN_CLR_LO = 12'h008;
   localparam logic [AW-1:0] OFS_EN_CLR_HI = 12'h00c;
   localparam logic [AW-1:0] OFS_PS_LO     = 12'h010;
   localparam logic [AW-1:0] OFS_PS_HI     = 12'h014;
   localparam logic [AW-1:0] OFS_PC_LO     = 12'h018;
   localparam logic [AW-1:0] OFS_PC_HI     = 12'h01c;
   localparam logic [AW-1:0] OFS_EVT_STS   = 12'h020;
   localparam logic [AW-1:0] OFS_EVT_MSK   = 12'h024;

   // event status / mask bit positions
   localparam int unsigned EVT_SET_IGNORED = 0;
   localparam int unsigned EVT_CLR_BLOCKED = 1;

   // reset values
   localparam logic [NUM_IRQ-1:0] EN_RST  = 50'h0;
   localparam logic [NUM_EVT-1:0] EVT_RST = 2'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic          awvalid;
      logic [AW-1:0] awaddr;
      logic          wvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bready;
      logic          arvalid;
      logic [AW-1:0] araddr;
      logic          rready;
   } iep_axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } iep_axil_rsp_t;

endpackage

// *** rtl/iep_bits.sv ***
/*
 contents: enable-clear and pending-set bit banks for 50 interrupt lines,
 with enable-set and pending-clear companions, an event status/mask pair
 and an AXI4-Lite register slave.
 assumes: peripheral requests and service indications are synchronous to
 aclk; the bus master keeps one write and one read outstanding at most.
*/
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

module iep_bits (
   // clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // register bus
   input  wire iep_pkg::iep_axil_req_t  bus_req,
   output var  iep_pkg::iep_axil_rsp_t  bus_rsp,
   // interrupt lines
   input  wire logic [49:0]             irq_req,
   input  wire logic [49:0]             irq_active,
   output var  logic [49:0]             irq_enable,
   output var  logic [49:0]             irq_pending,
   // event interrupt
   output var  logic                    evt_irq
);
   import iep_pkg::*;

   typedef struct packed {
      logic                 aw_ok;
      logic [AW-1:0]        aw_addr;
      logic                 w_ok;
      logic [31:0]          w_data;
      logic [3:0]           w_strb;
      logic                 awready;
      logic                 wready;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 arready;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic [NUM_IRQ-1:0]   en;
      logic [NUM_IRQ-1:0]   pend;
      logic [NUM_EVT-1:0]   sts;
      logic [NUM_EVT-1:0]   msk;
      logic                 irq;
   } iep_state_t;

   iep_state_t s_q;
   iep_state_t s_d;
   iep_state_t s_rst;

   logic               wr_fire;
   logic               ar_fire;
   logic [31:0]        wm;
   logic [NUM_IRQ-1:0] en_set;
   logic [NUM_IRQ-1:0] en_clr;
   logic [NUM_IRQ-1:0] p_set;
   logic [NUM_IRQ-1:0] p_clr;
   logic [NUM_EVT-1:0] evt;
   logic [NUM_EVT-1:0] sts_w1c;
   logic               wr_hit;

   function automatic logic [AW-1:0] word_addr(input logic [AW-1:0] a);
      return {a[AW-1:2], 2'b00};
   endfunction

   function automatic logic [31:0] byte_mask(input logic [3:0] strb);
      return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic is_mapped(input logic [AW-1:0] a);
      return word_addr(a) <= OFS_EVT_MSK;
   endfunction

   // upper words expose only 18 live bits
   function automatic logic [31:0] hi_word(input logic [NUM_IRQ-1:0] v);
      return {14'h0, v[NUM_IRQ-1:32]};
   endfunction

   function automatic logic [31:0] read_reg(input logic [AW-1:0] a, input iep_state_t s);
      logic [31:0] r;
      r = 32'h0;
      case (word_addr(a))
         OFS_EN_SET_LO, OFS_EN_CLR_LO: r = s.en[31:0];
         OFS_EN_SET_HI, OFS_EN_CLR_HI: r = hi_word(s.en);
         OFS_PS_LO, OFS_PC_LO:         r = s.pend[31:0];
         OFS_PS_HI, OFS_PC_HI:         r = hi_word(s.pend);
         OFS_EVT_STS:                  r = {30'h0, s.sts};
         OFS_EVT_MSK:                  r = {30'h0, s.msk};
         default:                      r = 32'h0;
      endcase
      return r;
   endfunction

   always_comb begin
      s_rst         = '0;
      s_rst.en      = EN_RST;
      s_rst.sts     = EVT_RST;
      s_rst.msk     = EVT_RST;
      s_rst.awready = 1'b1;
      s_rst.wready  = 1'b1;
      s_rst.arready = 1'b1;
      // pending state is not reset: it keeps whatever it powered up with
      s_rst.pend    = s_q.pend;
   end

   assign wr_fire = s_q.aw_ok & s_q.w_ok & ~s_q.bvalid;
   assign ar_fire = bus_req.arvalid & s_q.arready;
   assign wm      = s_q.w_data & byte_mask(s_q.w_strb);
   assign wr_hit  = is_mapped(s_q.aw_addr);

   // decode a completing write into set / clear vectors
   always_comb begin
      en_set  = '0;
      en_clr  = '0;
      p_set   = '0;
      p_clr   = '0;
      sts_w1c = '0;
      if (wr_fire) begin
         case (word_addr(s_q.aw_addr))
            OFS_EN_SET_LO: en_set[31:0]         = wm;
            OFS_EN_SET_HI: en_set[NUM_IRQ-1:32] = wm[HI_BITS-1:0];
            OFS_EN_CLR_LO: en_clr[31:0]         = wm;
            OFS_EN_CLR_HI: en_clr[NUM_IRQ-1:32] = wm[HI_BITS-1:0];
            OFS_PS_LO:     p_set[31:0]          = wm;
            OFS_PS_HI:     p_set[NUM_IRQ-1:32]  = wm[HI_BITS-1:0];
            OFS_PC_LO:     p_clr[31:0]          = wm;
            OFS_PC_HI:     p_clr[NUM_IRQ-1:32]  = wm[HI_BITS-1:0];
            OFS_EVT_STS:   sts_w1c              = wm[NUM_EVT-1:0];
            default:       sts_w1c              = '0;
         endcase
      end
      // a software set that finds the line disabled or already pending is noted
      evt                  = '0;
      evt[EVT_SET_IGNORED] = |(p_set & ~(s_q.en & ~s_q.pend));
      evt[EVT_CLR_BLOCKED] = |(p_clr & irq_active);
   end

   always_comb begin
      s_d = s_q;

      // write address and data are taken in either order, held until used
      if (bus_req.awvalid && s_q.awready) begin
         s_d.aw_ok   = 1'b1;
         s_d.aw_addr = bus_req.awaddr;
      end
      if (bus_req.wvalid && s_q.wready) begin
         s_d.w_ok   = 1'b1;
         s_d.w_data = bus_req.wdata;
         s_d.w_strb = bus_req.wstrb;
      end
      if (wr_fire) begin
         s_d.aw_ok  = 1'b0;
         s_d.w_ok   = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_q.bvalid && bus_req.bready) begin
         s_d.bvalid = 1'b0;
      end
      s_d.awready = ~s_d.aw_ok;
      s_d.wready  = ~s_d.w_ok;

      // read: one outstanding, data captured at the address handshake
      if (ar_fire) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = read_reg(bus_req.araddr, s_q);
         s_d.rresp  = is_mapped(bus_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_q.rvalid && bus_req.rready) begin
         s_d.rvalid = 1'b0;
      end
      s_d.arready = ~s_d.rvalid;

      // zero bits leave state alone: only ones reach the set/clear vectors
      s_d.en = (s_q.en | en_set) & ~en_clr;

      // clear is masked by service; hardware and software sets win over clear
      s_d.pend = (s_q.pend & ~(p_clr & ~irq_active))
               | (irq_req & s_q.en)
               | (p_set & s_q.en & ~s_q.pend);

      // only the low byte holds mask bits, so only its strobe matters
      if (wr_fire && word_addr(s_q.aw_addr) == OFS_EVT_MSK && s_q.w_strb[0]) begin
         s_d.msk = s_q.w_data[NUM_EVT-1:0];
      end
      // event set wins over a same-cycle write-one clear
      s_d.sts = (s_q.sts & ~sts_w1c) | evt;
      s_d.irq = |(s_d.sts & s_d.msk);

      if (!aresetn) begin
         s_d = s_rst;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   assign bus_rsp.awready = s_q.awready;
   assign bus_rsp.wready  = s_q.wready;
   assign bus_rsp.bvalid  = s_q.bvalid;
   assign bus_rsp.bresp   = s_q.bresp;
   assign bus_rsp.arready = s_q.arready;
   assign bus_rsp.rvalid  = s_q.rvalid;
   assign bus_rsp.rdata   = s_q.rdata;
   assign bus_rsp.rresp   = s_q.rresp;
   assign irq_enable      = s_q.en;
   assign irq_pending     = s_q.pend;
   assign evt_irq         = s_q.irq;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_dis_upper_bit: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_EN_CLR_HI && wm[0])
      |=> !s_q.en[32] && !irq_enable[32])
      else $error("upper enable-clear write did not disable line 32");

   a_en_read_back: assert property (
      (ar_fire && word_addr(bus_req.araddr) == OFS_EN_CLR_HI)
      |=> bus_rsp.rvalid && bus_rsp.rdata == {14'h0, $past(s_q.en[49:32])})
      else $error("enable-clear read does not show enable state");

   a_pend_set_lo: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_PS_LO)
      |=> ((irq_pending[31:0] & $past(wm & s_q.en[31:0]))
           == $past(wm & s_q.en[31:0])))
      else $error("pending-set write did not pend enabled lines");

   a_pend_set_dis: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_PS_HI
       && (wm[HI_BITS-1:0] & ~s_q.en[NUM_IRQ-1:32]) != 18'h0)
      |=> ((irq_pending[NUM_IRQ-1:32] ^ $past(s_q.pend[NUM_IRQ-1:32]))
           & $past(wm[HI_BITS-1:0] & ~s_q.en[NUM_IRQ-1:32])) == 18'h0)
      else $error("pending-set write pended a disabled line");

   a_set_pend_keep: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_PS_LO)
      |=> ((irq_pending[31:0] & $past(s_q.pend[31:0])) == $past(s_q.pend[31:0])))
      else $error("pending-set write dropped an already pending line");

   a_zero_write: assert property (
      (wr_fire && wm == 32'h0 && irq_req == 50'h0)
      |=> irq_enable == $past(s_q.en) && irq_pending == $past(s_q.pend))
      else $error("write of zeros changed enable or pending state");

   a_pend_read_back: assert property (
      (ar_fire && word_addr(bus_req.araddr) == OFS_PS_LO)
      |=> bus_rsp.rdata == $past(s_q.pend[31:0]))
      else $error("pending-set read does not show pending state");

   a_pend_clear: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_PC_LO && wm[3]
       && !irq_active[3] && !irq_req[3])
      |=> !irq_pending[3] ##1 (!irq_pending[3] || $past(irq_req[3])))
      else $error("pending-clear write did not clear the shared bit");

   // the upper clear word goes through its own decode path
   a_pend_clr_hi: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_PC_HI && wm[0]
       && !irq_active[32] && !irq_req[32])
      |=> !irq_pending[32])
      else $error("upper pending-clear write did not clear line 32");

   a_clr_in_service: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_PC_LO
       && (wm & irq_active[31:0] & s_q.pend[31:0]) != 32'h0)
      |=> (irq_pending[31:0] & $past(wm & irq_active[31:0] & s_q.pend[31:0]))
          == $past(wm & irq_active[31:0] & s_q.pend[31:0]))
      else $error("pending-clear acted on a line in service");

   a_upper_zero: assert property (
      (ar_fire && (word_addr(bus_req.araddr) == OFS_PS_HI
                   || word_addr(bus_req.araddr) == OFS_EN_CLR_HI))
      |=> bus_rsp.rdata[31:18] == 14'h0)
      else $error("upper word reads nonzero above bit 17");

   a_pend_read_hi: assert property (
      (ar_fire && word_addr(bus_req.araddr) == OFS_PS_HI)
      |=> bus_rsp.rdata == {14'h0, $past(s_q.pend[NUM_IRQ-1:32])})
      else $error("upper pending-set read does not show pending state");

   // a wide upper write must not spill into the low 32 lines
   a_hi_no_spill: assert property (
      (wr_fire && word_addr(s_q.aw_addr) == OFS_EN_CLR_HI)
      |=> irq_enable[31:0] == $past(s_q.en[31:0]))
      else $error("upper enable-clear write touched low lines");

   a_evt_irq_level: assert property (
      (s_q.sts & s_q.msk) != 2'h0 |-> evt_irq)
      else $error("event interrupt low while an unmasked event is set");

endmodule

`default_nettype wire

// *** test/iep_src_model.sv ***
/*
 iep_src_model: peripheral request and service-state sources for the bit banks.
 assumes: the bench gives per-line commands just after a rising edge of aclk.
*/
`timescale 1ns/1ns
`default_nettype none

module iep_src_model (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // bench commands
   input  wire logic [49:0] req_cmd,
   input  wire logic [49:0] act_cmd,
   // lines toward the banks
   output var  logic [49:0] irq_req,
   output var  logic [49:0] irq_active
);
   // registered: lines move only after an edge, like real synchronous sources
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_req    <= '0;
         irq_active <= '0;
      end else begin
         irq_req    <= req_cmd;
         irq_active <= act_cmd;
      end
   end
endmodule

`default_nettype wire

// *** test/tb.sv ***
/*
 tb: self-checking bench of the enable / pending bit banks.
 assumes: package, design and source model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
   import iep_pkg::*;
   logic          aclk;
   logic          aresetn;
   iep_axil_req_t req;
   iep_axil_rsp_t rsp;
   logic [49:0]   req_cmd;
   logic [49:0]   act_cmd;
   logic [49:0]   irq_req;
   logic [49:0]   irq_active;
   logic [49:0]   irq_enable;
   logic [49:0]   irq_pending;
   logic          evt_irq;
   logic [31:0]   rdat;
   logic [1:0]    resp;
   logic          e0;
   int            n_fail;
   int            tests_run;

   iep_bits uut (.aclk(aclk), .aresetn(aresetn), .bus_req(req), .bus_rsp(rsp),
      .irq_req(irq_req), .irq_active(irq_active), .irq_enable(irq_enable),
      .irq_pending(irq_pending), .evt_irq(evt_irq));
   iep_src_model src (.aclk(aclk), .aresetn(aresetn), .req_cmd(req_cmd),
      .act_cmd(act_cmd), .irq_req(irq_req), .irq_active(irq_active));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic summarize;
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [49:0] exp, input logic [49:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // each bus task opens on a fresh edge so no signal is assigned twice in a step
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) break;
      end
      if (i == 40) begin
         n_fail++;
         $display("Error write_wait expected bvalid seen timeout");
         summarize();
      end
      resp = rsp.bresp;
      req.bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      int i;
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) break;
      end
      if (i == 40) begin
         n_fail++;
         $display("Error read_wait expected rvalid seen timeout");
         summarize();
      end
      rdat = rsp.rdata;
      resp = rsp.rresp;
      req.rready <= 1'b0;
   endtask

   task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      rd(a);
      chk(nm, exp, rdat);
   endtask

   // pending state powers up unknown, so it is wiped before the pending words are checked
   task automatic t_reset;
      rc("en_clr_hi", OFS_EN_CLR_HI, 32'h0);
      chk("evt_irq", 50'h0, evt_irq);
      wr(OFS_PC_LO, 32'hffffffff);
      wr(OFS_PC_HI, 32'hffffffff);
      rc("ps_lo", OFS_PS_LO, 32'h0);
      rc("ps_hi", OFS_PS_HI, 32'h0);
   endtask

   task automatic t_enable;
      wr(OFS_EN_SET_LO, 32'hffffffff);
      wr(OFS_EN_SET_HI, 32'hffffffff);
      rc("en_clr_hi", OFS_EN_CLR_HI, 32'h0003ffff);
      wr(OFS_EN_CLR_HI, 32'h00020001);
      wr(OFS_EN_CLR_HI, 32'h0);
      rc("en_clr_hi", OFS_EN_CLR_HI, 32'h0001fffe);
      chk("irq_enable", 50'h1fffeffffffff, irq_enable);
      wr(OFS_EN_CLR_HI, 32'hfffc0000);
      rc("en_clr_hi", OFS_EN_CLR_HI, 32'h0001fffe);
   endtask

   task automatic t_pend;
      wr(OFS_PS_LO, 32'h80000001);
      wr(OFS_PS_LO, 32'h0);
      rc("ps_lo", OFS_PS_LO, 32'h80000001);
      chk("irq_pending", 50'h80000001, irq_pending);
      wr(OFS_PS_HI, 32'h00020003);
      rc("ps_hi", OFS_PS_HI, 32'h00000002);
      rc("evt_sts", OFS_EVT_STS, 32'h1);
      wr(OFS_EVT_MSK, 32'h0);
      e0 = evt_irq;
      wr(OFS_EVT_MSK, 32'h3);
      @(posedge aclk);
      chk("evt_irq", 50'h1, e0 ^ evt_irq);
      wr(OFS_EVT_STS, 32'h3);
      @(posedge aclk);
      chk("evt_irq", 50'h0, evt_irq);
      rc("evt_sts", OFS_EVT_STS, 32'h0);
   endtask

   task automatic t_clear;
      act_cmd <= 50'h80000000;
      wr(OFS_PC_LO, 32'hffffffff);
      rc("ps_lo", OFS_PS_LO, 32'h80000000);
      rc("evt_sts", OFS_EVT_STS, 32'h2);
      act_cmd <= 50'h0;
      wr(OFS_PC_LO, 32'h80000000);
      rc("ps_lo", OFS_PS_LO, 32'h0);
   endtask

   // one-cycle request pulses: line 5 enabled, line 32 disabled
   task automatic t_hw;
      req_cmd <= 50'h100000020;
      @(posedge aclk);
      req_cmd <= 50'h0;
      rc("ps_lo", OFS_PS_LO, 32'h20);
      rc("ps_hi", OFS_PS_HI, 32'h2);
   endtask

   task automatic t_bad;
      wr(12'h100, 32'hffffffff);
      chk("bresp", RESP_SLVERR, resp);
      rd(12'h100);
      chk("rresp", RESP_SLVERR, resp);
      chk("rdata", 50'h0, rdat);
   endtask

   initial begin
      n_fail = 0;
      tests_run = 0;
      aresetn = 1'b0;
      req = '0;
      req_cmd = '0;
      act_cmd = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_enable();
      t_pend();
      t_clear();
      t_hw();
      t_bad();
      summarize();
   end
endmodule

`default_nettype wire
